// *** hw/ccsc_div.sv ***
// cpu clock enable and instruction tick generator
`timescale 1ns/100ps
module ccsc_div (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       main_run,
  input  wire logic       sub_run,
  input  wire logic       sub_mode,
  input  wire logic [2:0] div,
  input  wire logic       sub_tick,
  output logic            cpu_clk_en,
  output logic            instr_tick
);
  import ccsc_pkg::*;

  // ==========================================================
  // prescaler
  logic [3:0] pre_q;      // main clock prescale count
  logic [3:0] pre_last;   // terminal count for divider code
  logic       phase_q;    // second cpu clock of an instruction
  logic       tick_c;     // one cpu clock period elapsed
  logic [1:0] since_q;    // cpu clocks since last instruction tick

  assign pre_last = 4'((5'h01 << ccsc_clamp_div(div)) - 5'h01);

  // sub mode ignores the divider entirely
  always_comb begin
    if (sub_mode)
      tick_c = sub_run & sub_tick;
    else
      tick_c = main_run & (pre_q >= pre_last);
  end

  // main clock divide counter, wraps on terminal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_q <= 4'h0;
    else if (sub_mode)
      pre_q <= 4'h0;
    else if (main_run)
      pre_q <= (pre_q >= pre_last) ? 4'h0 : pre_q + 4'h1;
  end

  // instruction time is two cpu clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b0;
      instr_tick <= 1'b0;
      phase_q    <= 1'b0;
    end else begin
      cpu_clk_en <= tick_c;
      instr_tick <= tick_c & phase_q;
      if (tick_c)
        phase_q <= ~phase_q;
    end
  end

  // helper: cpu clocks seen since last instruction tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      since_q <= 2'h0;
    else if (instr_tick)
      since_q <= 2'h0;
    else if (cpu_clk_en && since_q != 2'h3)
      since_q <= since_q + 2'h1;
  end

  AST_INSTR_TWO_CLK: assert property (
    @(posedge pclk) disable iff (!presetn)
    instr_tick |-> (cpu_clk_en && since_q == 2'h1))
    else $error("instruction tick not on second cpu clock");

  AST_SUB_RATE: assert property (
    @(posedge pclk) disable iff (!presetn)
    (cpu_clk_en && sub_mode && $past(sub_mode)) |-> $past(sub_tick))
    else $error("sub mode cpu clock without subsystem tick");

endmodule // ccsc_div

// *** hw/ccsc_top.sv ***
// cpu clock source and divider control with apb register access
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module ccsc_top #(
  parameter int STAB_CYCLES = 2 ** ccsc_pkg::STAB_EXP
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        sub_tick,
  output logic             cpu_clk_en,
  output logic             instr_tick,
  output logic             cpu_hold,
  output logic             main_osc_en,
  output logic             sub_fb_cut,
  output logic             wdt_halt,
  output logic             active_source_status
);
  import ccsc_pkg::*;

  // ==========================================================
  // state
  ccsc_ctrl_s  ctrl_q;          // processor_clock_ctrl image
  ccsc_sw_e    sw_q;            // switch engine state
  logic [6:0]  cnt_q;           // instructions left before switch
  logic [2:0]  act_div_q;       // divider in use
  logic [17:0] stab_q;          // stabilization count
  logic        acc;             // access phase present
  logic        fire;            // transfer completes this edge
  logic        wr_ctrl;         // control write takes effect
  logic        hit_ctrl;        // address decode: control
  logic        hit_stat;        // address decode: status
  ccsc_ctrl_s  wr_val;          // written control image
  logic        differs;         // written setting differs from active
  logic [6:0]  load_val;        // switch delay for this write
  logic        expire;          // switch takes effect now
  logic        div_clk_en;      // cpu clock enable from divider
  logic        div_instr;       // instruction tick from divider
  logic [31:0] rd_c;            // read data mux

  localparam logic [17:0] STAB_LAST = 18'(STAB_CYCLES - 1);

  // ==========================================================
  // apb slave: one wait state, pready registered
  assign acc      = psel & penable;
  assign fire     = acc & pready;
  assign hit_ctrl = (paddr == OFF_CTRL);
  assign hit_stat = (paddr == OFF_STAT);
  assign wr_ctrl  = fire & pwrite & hit_ctrl;
  assign wr_val   = ccsc_ctrl_s'({pwdata[BIT_STOP], pwdata[BIT_FRC],
                                  pwdata[BIT_CSS],
                                  pwdata[BIT_DIV_LO +: 3]});

  // read data image, reserved bits zero
  always_comb begin
    rd_c = 32'h0;
    if (hit_ctrl) begin
      rd_c[BIT_DIV_LO +: 3] = ctrl_q.div;
      rd_c[BIT_CSS]         = ctrl_q.clock_source_select;
      rd_c[BIT_ACTIVE]      = active_source_status;
      rd_c[BIT_FRC]         = ctrl_q.frc;
      rd_c[BIT_STOP]        = ctrl_q.stop;
    end else if (hit_stat) begin
      rd_c[BIT_HOLD]    = cpu_hold;
      rd_c[BIT_PEND]    = (sw_q == SW_WAIT);
      rd_c[BIT_MAIN_ON] = main_osc_en;
    end
  end

  // answer one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= (acc & ~pready & ~pwrite) ? rd_c : 32'h0;
      // unmapped address or write to status is an error
      pslverr <= acc & ~pready & ~(hit_ctrl | (hit_stat & ~pwrite));
    end
  end

  // control register, software view of the settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      ctrl_q <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= wr_val;
  end

  // ==========================================================
  // switchover engine
  // a write that differs from the active setting arms the counter;
  // the delay is taken from the setting in use before the write
  assign differs  = (wr_val.clock_source_select != active_source_status) |
                    (wr_val.div != act_div_q);
  // divider change on entry to sub is not allowed by software,
  // so the old divider alone decides the entry delay
  assign load_val = ccsc_switch_delay(active_source_status,
                                      wr_val.clock_source_select, act_div_q);
  assign expire   = (sw_q == SW_WAIT) & div_instr &
                    (cnt_q == SUB_EXIT_DELAY);

  // count down old instruction times, then switch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_q  <= SW_IDLE;
      cnt_q <= 7'h0;
    end else if (wr_ctrl && differs) begin
      sw_q  <= SW_WAIT;
      cnt_q <= load_val;
    end else begin
      unique case (sw_q)
        SW_IDLE: begin
          cnt_q <= 7'h0;
        end
        SW_WAIT: begin
          if (expire)
            sw_q <= SW_IDLE;
          if (div_instr)
            cnt_q <= cnt_q - 7'h1;
        end
      endcase
    end
  end

  // active selection changes only on an instruction boundary
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_source_status <= 1'b0;
      act_div_q            <= DIV_SLOWEST;
    end else if (expire) begin
      active_source_status <= ctrl_q.clock_source_select;
      act_div_q            <= ctrl_q.div;
    end
  end

  // ==========================================================
  // oscillator control and reset stabilization
  // main oscillator is off during reset, on after release; the
  // stop bit takes effect only once the cpu runs on the sub clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_osc_en <= 1'b0;
      sub_fb_cut  <= 1'b0;
    end else begin
      main_osc_en <= ~(ctrl_q.stop & active_source_status);
      sub_fb_cut  <= ctrl_q.frc;
    end
  end

  // hold execution for the stabilization count after reset;
  // later restarts are timed by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stab_q   <= 18'h0;
      cpu_hold <= 1'b1;
    end else if (cpu_hold && main_osc_en) begin
      stab_q <= stab_q + 18'h1;
      if (stab_q == STAB_LAST)
        cpu_hold <= 1'b0;
    end
  end

  // watchdog halts while the cpu runs on the sub clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      wdt_halt <= 1'b0;
    else
      wdt_halt <= active_source_status;
  end

  // ==========================================================
  // cpu clock generation
  ccsc_div u_div (
    .pclk       (pclk),
    .presetn    (presetn),
    .main_run   (main_osc_en & ~cpu_hold),
    .sub_run    (~cpu_hold),
    .sub_mode   (active_source_status),
    .div        (act_div_q),
    .sub_tick   (sub_tick),
    .cpu_clk_en (div_clk_en),
    .instr_tick (div_instr)
  );

  assign cpu_clk_en = div_clk_en;
  assign instr_tick = div_instr;

  // ==========================================================
  // checks
  AST_WDT_HALT_FOLLOWS: assert property (
    @(posedge pclk) disable iff (!presetn)
    ##1 wdt_halt == $past(active_source_status))
    else $error("watchdog halt does not follow active source");

  AST_STATUS_READ: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc && !pready && !pwrite && hit_ctrl)
      |=> prdata[BIT_ACTIVE] == $past(active_source_status))
    else $error("status bit read does not show active source");

  AST_MAIN_STOP_ONLY_SUB: assert property (
    @(posedge pclk) disable iff (!presetn)
    (!main_osc_en && !$past(cpu_hold))
      |-> $past(ctrl_q.stop && active_source_status))
    else $error("main oscillator stopped while not on sub clock");

  AST_NO_EXEC_IN_HOLD: assert property (
    @(posedge pclk) disable iff (!presetn)
    cpu_hold |=> !cpu_clk_en)
    else $error("cpu clock ran during stabilization hold");

  AST_ACTIVE_ONLY_ON_EXPIRE: assert property (
    @(posedge pclk) disable iff (!presetn)
    $changed(active_source_status) |-> $past(expire))
    else $error("source changed without switch delay expiry");

  AST_MAIN_DIV_DELAY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && differs && !active_source_status && !wr_val.clock_source_select)
      |=> cnt_q == (MAIN_DELAY_BASE >> ccsc_clamp_div($past(act_div_q))))
    else $error("main divider switch delay wrong");

  AST_SUB_ENTRY_DELAY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && differs && !active_source_status && wr_val.clock_source_select)
      |=> cnt_q == SUB_ENTRY_DLY[ccsc_clamp_div($past(act_div_q))])
    else $error("main to sub switch delay wrong");

  AST_SUB_EXIT_DELAY: assert property (
    @(posedge pclk) disable iff (!presetn)
    (wr_ctrl && differs && active_source_status)
      |=> (sw_q == SW_WAIT && cnt_q == SUB_EXIT_DELAY))
    else $error("sub to main switch delay not one instruction");

  AST_RESET_SLOWEST: assert property (
    @(posedge pclk) disable iff (!presetn)
    $fell(cpu_hold) |-> (act_div_q == DIV_SLOWEST
                         || $past(expire, 2)))
    else $error("execution did not start at slowest divider");

endmodule // ccsc_top

// *** shared/ccsc_pkg.sv ***
// constants, types and helpers shared by the cpu clock switch control block
package ccsc_pkg;

  // ==========================================================
  // register map (byte addresses, one 32-bit word each)
  localparam logic [7:0] OFF_CTRL   = 8'h00; // processor_clock_ctrl
  localparam logic [7:0] OFF_STAT   = 8'h04; // block status

  // processor_clock_ctrl field positions
  localparam int BIT_DIV_LO  = 0;   // cpu divider bits 0..2
  localparam int BIT_CSS     = 4;   // clock_source_select
  localparam int BIT_ACTIVE  = 5;   // active_source_status, read only
  localparam int BIT_FRC     = 6;   // subsystem feedback resistor cut
  localparam int BIT_STOP    = 7;   // main_osc_stop

  // status register field positions
  localparam int BIT_HOLD    = 0;   // reset stabilization in progress
  localparam int BIT_PEND    = 1;   // clock switchover pending
  localparam int BIT_MAIN_ON = 2;   // main oscillator enabled

  // ==========================================================
  // control register image
  typedef struct packed {
    logic       stop;   // main_osc_stop
    logic       frc;    // feedback resistor cut
    logic       clock_source_select;    // clock_source_select
    logic [2:0] div;    // cpu divider code
  } ccsc_ctrl_s;

  // reset value 04h: slowest main divider, main clock source
  localparam ccsc_ctrl_s CTRL_RST = '{1'b0, 1'b0, 1'b0, 3'h4};

  // switch engine states
  typedef enum logic {SW_IDLE, SW_WAIT} ccsc_sw_e;

  // ==========================================================
  // timing constants
  localparam int         STAB_EXP        = 17;  // 2^17 main periods
  localparam logic [2:0] DIV_SLOWEST     = 3'h4;
  localparam logic [6:0] MAIN_DELAY_BASE = 7'h10; // 16 at code 000
  localparam logic [6:0] SUB_EXIT_DELAY  = 7'h01; // sub to main
  // main to sub delays, index = old divider code
  localparam logic [4:0][6:0] SUB_ENTRY_DLY =
    {7'h05, 7'h0a, 7'h14, 7'h27, 7'h4d};

  // codes above the slowest are treated as the slowest
  function automatic logic [2:0] ccsc_clamp_div(input logic [2:0] d);
    return (d > DIV_SLOWEST) ? DIV_SLOWEST : d;
  endfunction

  // instructions at the old clock before a switch takes effect
  function automatic logic [6:0] ccsc_switch_delay(
    input logic       from_sub,
    input logic       to_sub,
    input logic [2:0] old_div);
    logic [2:0] d;
    d = ccsc_clamp_div(old_div);
    if (from_sub)
      return SUB_EXIT_DELAY;
    else if (to_sub)
      return SUB_ENTRY_DLY[d];
    else
      return MAIN_DELAY_BASE >> d;
  endfunction

endpackage

// *** verif/ccsc_tb_top.sv ***
// self-checking testbench of the cpu clock switch control block
`timescale 1ns/100ps
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin \
  n_fail++; $display("mismatch %s expected %0h seen %0h", what, exp, got); \
  end end
module ccsc_tb_top;
  import ccsc_pkg::*;
  // ==========================================================
  // signals and settings
  localparam int STAB = 16;              // shortened stabilization hold
  localparam int SUBP = 8;               // pclk cycles per sub_tick
  localparam int ENT [5] = '{77, 39, 20, 10, 5}; // main to sub delays
  logic        pclk, presetn, psel, penable, pwrite, sub_tick;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, cpu_clk_en, instr_tick, cpu_hold;
  logic        main_osc_en, sub_fb_cut, wdt_halt, active_source_status;
  int          n_fail, check_count, sub_cnt;

  // ==========================================================
  // design under test
  ccsc_top #(.STAB_CYCLES(STAB)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sub_tick(sub_tick),
    .cpu_clk_en(cpu_clk_en), .instr_tick(instr_tick),
    .cpu_hold(cpu_hold), .main_osc_en(main_osc_en),
    .sub_fb_cut(sub_fb_cut), .wdt_halt(wdt_halt),
    .active_source_status(active_source_status));

  // ==========================================================
  // clock and subsystem tick source
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // one pulse every SUBP cycles stands for the subsystem clock
  // it runs stably from the start and never enters standby
  always @(posedge pclk) begin
    sub_cnt  <= (sub_cnt == SUBP - 1) ? 0 : sub_cnt + 1;
    sub_tick <= (sub_cnt == SUBP - 1);
  end

  // ==========================================================
  // reporting
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // a wait that ran out of cycles
  task automatic lost(input string w);
    n_fail++;
    $display("mismatch %s expected done seen timeout", w);
    end_of_test();
  endtask

  // ==========================================================
  // apb master: setup, access until pready, then release
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) lost("pready");
    q   = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // control register write
  task automatic wr(input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, OFF_CTRL, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask

  // ==========================================================
  // instruction tick measurements
  // ticks seen until the active source reaches lvl
  task automatic to_active(input logic lvl, output int n);
    int c;
    n = 0;
    for (c = 0; c < 3000 && active_source_status !== lvl; c++) begin
      @(posedge pclk);
      if (instr_tick === 1'b1) n++;
    end
    if (active_source_status !== lvl) lost("active source");
  endtask
  // ticks seen until a gap longer than gmax appears
  task automatic ticks_fast(input int gmax, output int n);
    int g;
    n = 0;
    g = 0;
    while (g <= gmax && n < 100) begin
      @(posedge pclk);
      g++;
      if (instr_tick === 1'b1) begin
        n++;
        g = 0;
      end
    end
  endtask
  // cycles between two consecutive ticks
  task automatic period(output int p);
    int c;
    c = 0;
    p = 0;
    do @(posedge pclk); while (instr_tick !== 1'b1 && ++c < 500);
    do begin
      @(posedge pclk);
      p++;
    end while (instr_tick !== 1'b1 && p < 500);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset;
    int n;
    logic [31:0] r;
    n = 0;
    while (main_osc_en !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    n = 0;
    while (cpu_hold === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    `CHK("hold length", STAB, n)
    rd(OFF_CTRL, r);
    `CHK("ctrl reset", 32'h04, r)
    period(n);
    `CHK("slowest period", 32, n)
    // four cpu clocks in two slowest instructions
    n = 0;
    repeat (64) begin
      @(posedge pclk);
      if (cpu_clk_en === 1'b1) n++;
    end
    `CHK("cpu clocks", 4, n)
  endtask
  // main to main from each faster code back to the slowest
  task automatic t_main;
    int n;
    logic [31:0] r;
    for (int d = 0; d < 4; d++) begin
      wr(32'h20 | 32'(d));
      repeat (80) @(posedge pclk);
      wr(32'h04);
      ticks_fast(2 ** (d + 1) + 2, n);
      `CHK("main delay", 16 >> d, n)
    end
    rd(OFF_CTRL, r);
    `CHK("ctrl ro bit", 32'h04, r)
    // stop bit set on the main clock leaves the oscillator running
    wr(32'h84);
    repeat (4) @(posedge pclk);
    `CHK("osc stop on main", 1'b1, main_osc_en)
  endtask
  // sub clock entry with stop bit, divider ignored, restart
  task automatic t_sub;
    int n;
    logic [31:0] r;
    wr(32'h94);
    `CHK("osc kept on main", 1'b1, main_osc_en)
    to_active(1'b1, n);
    `CHK("entry delay slowest", 5, n)
    repeat (2) @(posedge pclk);
    `CHK("wdt halt", 1'b1, wdt_halt)
    `CHK("osc stopped", 1'b0, main_osc_en)
    rd(OFF_CTRL, r);
    `CHK("ctrl on sub", 32'hb4, r)
    wr(32'hb0);
    repeat (40) @(posedge pclk);
    period(n);
    `CHK("sub period", 2 * SUBP, n)
    wr(32'h30);
    repeat (2) @(posedge pclk);
    `CHK("osc restart", 1'b1, main_osc_en)
    // software times the restart before leaving the sub clock
    repeat (STAB) @(posedge pclk);
  endtask
  // leave and re-enter the sub clock from each divider code 0 to 4
  task automatic t_loop;
    int n;
    for (int d = 0; d < 5; d++) begin
      wr(32'(d));
      to_active(1'b0, n);
      `CHK("exit delay", 1, n)
      wr(32'h10 | 32'(d));
      to_active(1'b1, n);
      `CHK("entry delay", ENT[d], n)
    end
    wr(32'h04);
    to_active(1'b0, n);
    repeat (2) @(posedge pclk);
    `CHK("wdt running", 1'b0, wdt_halt)
  endtask
  // refused accesses and final status
  task automatic t_err;
    logic [31:0] r;
    logic        e;
    int          n;
    apb(1'b0, 8'h08, 32'h0, r, e);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, r)
    apb(1'b1, OFF_STAT, 32'hff, r, e);
    `CHK("status write err", 1'b1, e)
    // feedback cut bit reaches its pin
    wr(32'h44);
    repeat (2) @(posedge pclk);
    `CHK("feedback cut", 1'b1, sub_fb_cut)
    // divider code 7 runs as the slowest setting
    wr(32'h47);
    repeat (40) @(posedge pclk);
    period(n);
    `CHK("code 7 period", 32, n)
    rd(OFF_STAT, r);
    `CHK("status", 32'h04, r)
  endtask

  // ==========================================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    n_fail = 0;
    check_count = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_main();
    t_sub();
    t_loop();
    t_err();
    end_of_test();
  end
endmodule // ccsc_tb_top
